/* File: logic/sar_adc_pkg.sv */
package sar_adc_pkg;
    localparam int         RESULT_W        = 10;
    localparam int         THRESH_W        = 8;
    localparam int         MODE_BIT        = 3;
    localparam logic [3:0] MODE_RESET      = 4'h0;
    localparam logic [9:0] RESULT_RESET    = 10'h000;
    localparam logic [7:0] THRESH_RESET    = 8'h00;
    localparam int         CONV_CYCLES     = 62;
    localparam int         COMP_CYCLES     = 8;
    localparam int         CYCLES_PER_BIT  = 6;
    localparam int         SETTLE_PHASE    = 4;
    localparam int         MACHINE_DIV     = 4;
    localparam logic [2:0] SEL_INPUT0      = 3'h0;
    localparam logic [2:0] SEL_INPUT1      = 3'h1;
    localparam logic [2:0] SEL_INPUT4      = 3'h4;
    localparam logic [2:0] SEL_INPUT5      = 3'h5;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CONVERT = 2'b01,
        ST_COMPARE = 2'b10
    } op_state_type;
endpackage : sar_adc_pkg

/* File: logic/machine_cycle_divider.sv */
module machine_cycle_divider
    import sar_adc_pkg::*;
#(
    parameter int DIV = MACHINE_DIV
)(
    input  wire logic i_clk,
    input  wire logic i_reset,
    output logic      o_tick
);
    logic [7:0] count_r;
    logic       wrap;

    assign wrap = (count_r == 8'(DIV - 1));

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            count_r <= 8'h00;
            o_tick  <= 1'b0;
        end
        else
        begin
            count_r <= wrap ? 8'h00 : count_r + 8'h01;
            o_tick  <= wrap;
        end
    end
endmodule : machine_cycle_divider

/* File: logic/sar_adc_comparator_control.sv */
module sar_adc_comparator_control
    import sar_adc_pkg::*;
#(
    parameter int DIV = MACHINE_DIV
)(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_start_instr,
    input  wire logic       i_skip_test_instr,
    input  wire logic       i_write_mode_instr,
    input  wire logic       i_read_mode_instr,
    input  wire logic       i_read_high_instr,
    input  wire logic       i_read_low_instr,
    input  wire logic       i_write_threshold_instr,
    input  wire logic [3:0] i_acc_a,
    input  wire logic [3:0] i_reg_b,
    input  wire logic       i_irq_accept,
    input  wire logic       i_irq_enable,
    input  wire logic       i_dac_below_input,
    output logic            o_machine_cycle,
    output logic [3:0]      o_acc_a,
    output logic            o_acc_a_load,
    output logic [3:0]      o_reg_b,
    output logic            o_reg_b_load,
    output logic            o_skip,
    output logic            o_done_flag,
    output logic            o_irq_request,
    output logic            o_busy,
    output logic            o_compare_mode,
    output logic [2:0]      o_input_select,
    output logic            o_input_valid,
    output logic [9:0]      o_dac_code
);
    // valid analog input code
    function automatic logic input_code_valid(input logic [2:0] code);
        input_code_valid = (code == SEL_INPUT0) || (code == SEL_INPUT1) ||
                           (code == SEL_INPUT4) || (code == SEL_INPUT5);
    endfunction : input_code_valid

    op_state_type state_r;
    logic [3:0]   mode_r;
    logic [9:0]   result_r;
    logic [7:0]   threshold_r;
    logic [5:0]   count_r;
    logic [2:0]   phase_r;
    logic [3:0]   bit_r;
    logic         done_flag_r;
    logic         below_meta_r;
    logic         below_s_r;
    logic         tick;
    logic [6:0]   ticks_seen_r;
    logic         cmp_op_r;

    logic         cmp_mode;
    logic         start_ok;
    logic         conv_finish;
    logic         comp_finish;
    logic         vin_low;
    logic         set_ev;
    logic         clr_ev;
    logic         flag_nxt;
    logic         bit_in_range;
    logic [9:0]   bit_mask;
    logic [9:0]   dac_nxt;
    logic [7:0]   read_high_nxt;

    machine_cycle_divider #(
        .DIV (DIV)
    ) u_div (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .o_tick  (tick)
    );

    assign cmp_mode      = mode_r[MODE_BIT];
    assign start_ok      = i_start_instr && (state_r == ST_IDLE);
    assign conv_finish   = (state_r == ST_CONVERT) && tick && (count_r == 6'(CONV_CYCLES - 1));
    assign comp_finish   = (state_r == ST_COMPARE) && tick && (count_r == 6'(COMP_CYCLES - 1));
    assign vin_low       = !below_s_r;
    assign bit_in_range  = (bit_r < 4'(RESULT_W));
    assign bit_mask      = bit_in_range ? (10'h001 << bit_r) : 10'h000;
    assign set_ev        = conv_finish || (comp_finish && vin_low);
    assign clr_ev        = i_irq_accept || (i_skip_test_instr && done_flag_r);
    assign flag_nxt      = set_ev ? 1'b1 : (clr_ev ? 1'b0 : done_flag_r);
    assign dac_nxt       = cmp_mode ? {threshold_r, 2'b00} : result_r;
    assign read_high_nxt = cmp_mode ? threshold_r : result_r[9:2];

    // analog comparator output is asynchronous
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            below_meta_r <= 1'b0;
            below_s_r    <= 1'b0;
        end
        else
        begin
            below_meta_r <= i_dac_below_input;
            below_s_r    <= below_meta_r;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            mode_r <= MODE_RESET;
        else if (i_write_mode_instr)
            mode_r <= i_acc_a;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            threshold_r <= THRESH_RESET;
        else if (i_write_threshold_instr && cmp_mode)
            threshold_r <= {i_reg_b, i_acc_a};
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_r  <= ST_IDLE;
            count_r  <= 6'h00;
            phase_r  <= 3'h0;
            bit_r    <= 4'h0;
            cmp_op_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_ok)
                    begin
                        state_r  <= cmp_mode ? ST_COMPARE : ST_CONVERT;
                        cmp_op_r <= cmp_mode;
                        count_r  <= 6'h00;
                        phase_r  <= 3'h0;
                        bit_r    <= 4'(RESULT_W - 1);
                    end
                end
                ST_CONVERT:
                begin
                    if (conv_finish)
                        state_r <= ST_IDLE;
                    else if (tick)
                    begin
                        count_r <= count_r + 6'h01;
                        if (phase_r == 3'(CYCLES_PER_BIT - 1))
                        begin
                            phase_r <= 3'h0;
                            bit_r   <= bit_r - 4'h1;
                        end
                        else
                            phase_r <= phase_r + 3'h1;
                    end
                end
                ST_COMPARE:
                begin
                    if (comp_finish)
                        state_r <= ST_IDLE;
                    else if (tick)
                        count_r <= count_r + 6'h01;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            result_r <= RESULT_RESET;
        else if (start_ok && !cmp_mode)
            result_r <= RESULT_RESET;
        else if ((state_r == ST_CONVERT) && tick && (phase_r == 3'h0))
            result_r <= result_r | bit_mask;
        else if ((state_r == ST_CONVERT) && tick && (phase_r == 3'(SETTLE_PHASE)) && !below_s_r)
            result_r <= result_r & ~bit_mask;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            done_flag_r   <= 1'b0;
            o_skip        <= 1'b0;
            o_irq_request <= 1'b0;
        end
        else
        begin
            done_flag_r   <= flag_nxt;
            o_skip        <= i_skip_test_instr && done_flag_r;
            o_irq_request <= flag_nxt && i_irq_enable;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_acc_a      <= 4'h0;
            o_acc_a_load <= 1'b0;
            o_reg_b      <= 4'h0;
            o_reg_b_load <= 1'b0;
        end
        else
        begin
            o_acc_a_load <= i_read_mode_instr || i_read_high_instr || i_read_low_instr;
            o_reg_b_load <= i_read_high_instr;
            if (i_read_high_instr)
            begin
                o_acc_a <= read_high_nxt[3:0];
                o_reg_b <= read_high_nxt[7:4];
            end
            else if (i_read_low_instr)
                o_acc_a <= {result_r[1:0], 2'b00};
            else if (i_read_mode_instr)
                o_acc_a <= mode_r;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_input_select  <= 3'h0;
            o_input_valid   <= 1'b0;
            o_dac_code      <= 10'h000;
            o_busy          <= 1'b0;
            o_compare_mode  <= 1'b0;
            o_done_flag     <= 1'b0;
            o_machine_cycle <= 1'b0;
        end
        else
        begin
            o_input_select  <= mode_r[2:0];
            o_input_valid   <= input_code_valid(mode_r[2:0]);
            o_dac_code      <= dac_nxt;
            o_busy          <= (state_r != ST_IDLE) && !conv_finish && !comp_finish;
            o_compare_mode  <= cmp_mode;
            o_done_flag     <= flag_nxt;
            o_machine_cycle <= tick;
        end
    end

    // helper: machine cycles spent busy since the last accepted start, held once idle
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            ticks_seen_r <= 7'h00;
        else if (start_ok)
            ticks_seen_r <= 7'h00;
        else if ((state_r != ST_IDLE) && tick)
            ticks_seen_r <= ticks_seen_r + 7'h01;
    end

    conv_length_a: assert property (@(posedge i_clk) disable iff (i_reset)
        conv_finish |=> (ticks_seen_r == 7'(CONV_CYCLES)) && (state_r == ST_IDLE))
        else $error("conversion did not end after 62 machine cycles");

    comp_length_a: assert property (@(posedge i_clk) disable iff (i_reset)
        comp_finish |=> (ticks_seen_r == 7'(COMP_CYCLES)) && !o_busy)
        else $error("comparator did not end after 8 machine cycles");

    start_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
        start_ok && !cmp_mode |=> result_r == RESULT_RESET)
        else $error("result not cleared at conversion start");

    busy_ignore_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r != ST_IDLE) && i_start_instr |=> ticks_seen_r >= $past(ticks_seen_r))
        else $error("start accepted while busy");

    flag_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
        conv_finish |=> done_flag_r && o_done_flag)
        else $error("flag not set on conversion end");

    skip_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_skip_test_instr && done_flag_r && !set_ev |=> o_skip && !done_flag_r)
        else $error("taken skip did not clear flag");

    low_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_read_low_instr && !i_read_high_instr |=> o_acc_a_load && (o_acc_a == {$past(result_r[1:0]), 2'b00}))
        else $error("low result read wrong");

    thresh_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_write_threshold_instr && !cmp_mode |=> $stable(threshold_r))
        else $error("threshold written outside comparator mode");

    mode_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_write_mode_instr |=> mode_r == $past(i_acc_a) ##1 o_compare_mode == $past(mode_r[MODE_BIT]))
        else $error("mode register not loaded from accumulator");

    comp_flag_a: assert property (@(posedge i_clk) disable iff (i_reset)
        comp_finish && vin_low |=> done_flag_r)
        else $error("comparator flag not set on low input");

    high_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        i_read_high_instr && !cmp_mode |=> o_acc_a_load && o_reg_b_load &&
        ({o_reg_b, o_acc_a} == $past(result_r[9:2])))
        else $error("high result read wrong");

    irq_request_a: assert property (@(posedge i_clk) disable iff (i_reset)
        set_ev && i_irq_enable |=> o_irq_request)
        else $error("interrupt request not raised on completion");

    dac_thresh_a: assert property (@(posedge i_clk) disable iff (i_reset)
        cmp_mode |=> o_dac_code == {$past(threshold_r), 2'b00})
        else $error("DAC not driven from threshold");

    input_valid_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_input_valid |-> !o_input_select[1])
        else $error("unavailable input marked valid");

    trial_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == ST_CONVERT) && tick && (phase_r == 3'h0)
        |=> (result_r & $past(bit_mask)) == $past(bit_mask))
        else $error("trial bit not set");

    trial_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == ST_CONVERT) && tick && (phase_r == 3'(SETTLE_PHASE)) && !below_s_r
        |=> (result_r & $past(bit_mask)) == 10'h000)
        else $error("trial bit kept with DAC above input");
endmodule : sar_adc_comparator_control

/* File: verif/analog_front_end.sv */
module analog_front_end (
    input  wire logic [9:0] i_dac_code,
    input  wire logic [2:0] i_input_select,
    input  wire logic       i_input_valid,
    output logic            o_dac_below_input
);
    timeunit 1ns;
    timeprecision 1ps;
    int analog_input_voltage [0:7] = '{default: 0};
    assign o_dac_below_input = i_input_valid && (int'(i_dac_code) < analog_input_voltage[i_input_select]);
endmodule : analog_front_end

/* File: verif/sar_adc_comparator_control_tb.sv */
module sar_adc_comparator_control_tb
    import sar_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV_TB = 4;
    logic       i_clk        = 1'b0;
    logic       i_reset      = 1'b1;
    logic [7:0] strb         = 8'h00;
    logic [3:0] i_acc_a      = 4'h0;
    logic [3:0] i_reg_b      = 4'h0;
    logic       i_irq_enable = 1'b0;
    logic       dac_below;
    logic       o_machine_cycle;
    logic       o_skip;
    logic       o_acc_a_load;
    logic       o_reg_b_load;
    logic       o_done_flag;
    logic       o_irq_request;
    logic       o_busy;
    logic       o_compare_mode;
    logic       o_input_valid;
    logic [2:0] o_input_select;
    logic [3:0] o_acc_a;
    logic [3:0] o_reg_b;
    logic [9:0] o_dac_code;
    int         mismatches = 0;
    int         compares   = 0;
    int         skips      = 0;
    int         a_loads    = 0;
    int         b_loads    = 0;
    int         s0, analog_input_voltage, thr, res, i, sel, la, lb;
    int         sels [4]   = '{0, 1, 4, 5};

    sar_adc_comparator_control #(.DIV(DIV_TB)) sar_adc_comparator_control_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_start_instr(strb[0]), .i_skip_test_instr(strb[1]),
        .i_write_mode_instr(strb[2]), .i_read_mode_instr(strb[3]), .i_read_high_instr(strb[4]),
        .i_read_low_instr(strb[5]), .i_write_threshold_instr(strb[6]), .i_acc_a(i_acc_a),
        .i_reg_b(i_reg_b), .i_irq_accept(strb[7]), .i_irq_enable(i_irq_enable),
        .i_dac_below_input(dac_below), .o_machine_cycle(o_machine_cycle), .o_acc_a(o_acc_a),
        .o_acc_a_load(o_acc_a_load), .o_reg_b(o_reg_b), .o_reg_b_load(o_reg_b_load), .o_skip(o_skip),
        .o_done_flag(o_done_flag), .o_irq_request(o_irq_request), .o_busy(o_busy),
        .o_compare_mode(o_compare_mode), .o_input_select(o_input_select),
        .o_input_valid(o_input_valid), .o_dac_code(o_dac_code)
    );

    analog_front_end front_end_i (
        .i_dac_code(o_dac_code), .i_input_select(o_input_select),
        .i_input_valid(o_input_valid), .o_dac_below_input(dac_below)
    );

    always #20 i_clk = ~i_clk;

    always @(negedge i_clk)
    begin
        if (o_skip === 1'b1)
            skips++;
        if (o_acc_a_load === 1'b1)
            a_loads++;
        if (o_reg_b_load === 1'b1)
            b_loads++;
    end

    function automatic int sar(input int v);
        int r;
        r = 0;
        for (int k = 9; k >= 0; k--)
            if ((r | (1 << k)) < v)
                r = r | (1 << k);
        return r;
    endfunction : sar

    task wrap_up;
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task chk_val(input string nm, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_val

    task chk_cnt(input string nm, input int exp, input int got);
        compares++;
        if (got != exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_cnt

    // codes: 0 start 1 skip 2 wmode 3 rmode 4 rhigh 5 rlow 6 wthr 7 irq accept
    task op(input int code, input logic [3:0] a, input logic [3:0] b);
        @(posedge i_clk);
        strb <= 8'h01 << code;
        i_acc_a <= a;
        i_reg_b <= b;
        @(posedge i_clk);
        strb <= 8'h00;
        repeat (2) @(posedge i_clk);
        #1;
    endtask : op

    task run_op(input int exp_ticks, input logic restart, input logic [9:0] exp_dac);
        int ticks;
        ticks = 0;
        for (int k = 0; k < 2000; k++)
        begin
            @(posedge i_clk);
            strb <= (k == 0 || (restart && k == 23)) ? 8'h01 : 8'h00;
            #1;
            if (k == 8)
                chk_val("dac_code", exp_dac, o_dac_code);
            if (k == 12)
                chk_val("busy", 10'h001, {9'h000, o_busy});
            // ticks from the edge after the accepted start up to the finishing one
            if (k > 1 && o_machine_cycle === 1'b1)
                ticks++;
            if (k > 3 && o_busy !== 1'b1)
                break;
        end
        chk_cnt("op_ticks", exp_ticks, ticks);
    endtask : run_op

    initial
    begin
        void'($urandom(93913));
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        op(3, 4'h0, 4'h0);
        chk_val("mode_reset", 10'h000, {6'h00, o_acc_a});
        for (int m = 0; m < 16; m++)
        begin
            op(2, 4'(m), 4'h0);
            op(3, 4'h0, 4'h0);
            chk_val("mode_read", 10'(m), {6'h00, o_acc_a});
            chk_val("compare_mode", 10'(m >> 3), {9'h000, o_compare_mode});
            chk_val("input_valid", 10'(((m >> 1) & 1) ^ 1), {9'h000, o_input_valid});
            if (((m >> 1) & 1) == 0)
                chk_val("input_select", 10'(m & 7), {7'h00, o_input_select});
        end
        for (i = 0; i < 8; i++)
        begin
            sel = sels[i % 4];
            analog_input_voltage = (i == 0) ? 1023 : $urandom % 1024;
            front_end_i.analog_input_voltage[sel] = analog_input_voltage;
            res = sar(analog_input_voltage);
            op(2, 4'(sel), 4'h0);
            @(posedge i_clk);
            i_irq_enable <= i[0];
            run_op(CONV_CYCLES, i == 2, 10'h200);
            chk_val("done_flag", 10'h001, {9'h000, o_done_flag});
            chk_val("irq_request", 10'(i % 2), {9'h000, o_irq_request});
            la = a_loads;
            lb = b_loads;
            op(4, 4'h0, 4'h0);
            chk_val("result_high_b", 10'(res >> 6), {6'h00, o_reg_b});
            chk_val("result_high_a", 10'((res >> 2) & 15), {6'h00, o_acc_a});
            op(5, 4'hf, 4'h0);
            chk_val("result_low", 10'((res & 3) << 2), {6'h00, o_acc_a});
            chk_cnt("acc_a_loads", 2, a_loads - la);
            chk_cnt("reg_b_loads", 1, b_loads - lb);
            s0 = skips;
            op(i[0] ? 7 : 1, 4'h0, 4'h0);
            chk_cnt("skip_count", i[0] ? 0 : 1, skips - s0);
            chk_val("flag_cleared", 10'h000, {9'h000, o_done_flag});
            op(1, 4'h0, 4'h0);
            chk_cnt("skip_count", i[0] ? 0 : 1, skips - s0);
        end
        @(posedge i_clk);
        i_irq_enable <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            sel = sels[i % 4];
            thr = 1 + $urandom % 255;
            analog_input_voltage = (i < 2) ? thr * 4 + 1 - 2 * i : ($urandom % 256) * 4 + 1 + $urandom % 3;
            front_end_i.analog_input_voltage[sel] = analog_input_voltage;
            op(2, 4'(sel | 8), 4'h0);
            op(6, 4'(thr & 15), 4'(thr >> 4));
            op(4, 4'h0, 4'h0);
            chk_val("thresh_b", 10'(thr >> 4), {6'h00, o_reg_b});
            chk_val("thresh_a", 10'(thr & 15), {6'h00, o_acc_a});
            run_op(COMP_CYCLES, i == 1, 10'(thr * 4));
            s0 = skips;
            chk_val("compare_flag", 10'(analog_input_voltage < thr * 4), {9'h000, o_done_flag});
            op(1, 4'h0, 4'h0);
            chk_cnt("skip_count", int'(analog_input_voltage < thr * 4), skips - s0);
        end
        // mode change while idle, threshold write outside comparator mode ignored
        op(2, 4'h0, 4'h0);
        op(1, 4'h0, 4'h0);
        op(6, 4'h5, 4'ha);
        op(2, 4'h8, 4'h0);
        op(4, 4'h0, 4'h0);
        chk_val("thresh_kept_b", 10'(thr >> 4), {6'h00, o_reg_b});
        chk_val("thresh_kept_a", 10'(thr & 15), {6'h00, o_acc_a});
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        wrap_up();
    end
endmodule : sar_adc_comparator_control_tb
